// ===== inc/pam_pkg.sv
// Constants and types shared by the port A alternate-function multiplexer.
package pam_pkg;

	// Register indices on the plain register port.
	localparam logic [2:0] REG_SEL  = 3'h0;
	localparam logic [2:0] REG_DOUT = 3'h1;
	localparam logic [2:0] REG_DIR  = 3'h2;
	localparam logic [2:0] REG_PIN  = 3'h3;
	localparam logic [2:0] REG_STAT = 3'h4;

	// Values after reset.
	localparam logic [7:0] SEL_RST   = 8'h00;
	localparam logic [7:0] DOUT_RST  = 8'h00;
	localparam logic [7:0] DIR_RST   = 8'h00;
	localparam logic [7:0] OE_N_RST  = 8'hff;
	localparam logic [7:0] RDATA_RST = 8'h00;

	// Bit positions of the alternate functions within the select register.
	localparam int BIT_T0   = 0;
	localparam int BIT_T1   = 1;
	localparam int BIT_OE   = 2;
	localparam int BIT_CS   = 3;
	localparam int BIT_FWR  = 4;
	localparam int BIT_FRD  = 5;
	localparam int BIT_U0   = 6;
	localparam int BIT_U1   = 7;

	// Status register field positions.
	localparam int STAT_FETCH_SRC = 0;
	localparam int STAT_FETCH_EXT = 1;

	// Lowest code address that is fetched externally when the fetch source pin is low.
	localparam logic [15:0] CODE_BOUNDARY = 16'h1b40;

	// Serial port mode in which the data output pin carries serial data.
	localparam logic [1:0] UART_SYNC_MODE = 2'h0;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pam_bus_t;

	// Alternate signals offered by the processor core.
	typedef struct packed {
		logic       t0_ovf;
		logic       t0_lo_ovf;
		logic       t0_split;
		logic       t1_ovf;
		logic       t1_lo_ovf;
		logic       t1_split;
		logic       mem_oe_n;
		logic       mem_cs_n;
		logic       fifo_wr_n;
		logic       fifo_rd_n;
		logic       u0_data;
		logic [1:0] u0_mode;
		logic       u1_data;
		logic [1:0] u1_mode;
	} pam_alt_t;

	typedef struct packed {
		logic prev;
		logic pulse;
	} pam_pulse_state_t;

	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] dout;
		logic [7:0] dir;
		logic       fs_s1;
		logic       fs_s2;
		logic [7:0] pa_s1;
		logic [7:0] pa_s2;
		logic [7:0] db_s1;
		logic [7:0] db_s2;
		logic [7:0] pa_out;
		logic [7:0] pa_oe_n;
		logic       fetch_ext;
		logic [7:0] rdata;
		logic [7:0] db_out;
		logic       db_oe_n;
		logic       frd_prev;
		logic [7:0] fifo_rdata;
		logic       fifo_rvalid;
	} pam_state_t;

endpackage

// ===== core/pam_ovf_pulse.sv
// One-cycle overflow pulse of one timer, taken from the low byte in split mode.
`timescale 1ns/1ps
module pam_ovf_pulse (
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	input  wire logic i_ovf,
	input  wire logic i_lo_ovf,
	input  wire logic i_split,
	output logic      o_pulse
);
	pam_pkg::pam_pulse_state_t st;
	pam_pkg::pam_pulse_state_t next_st;
	logic                      src;

	always_comb begin
		// In split mode only the low-byte counter drives the pulse.
		src           = i_split ? i_lo_ovf : i_ovf; // R5 R8
		next_st       = st;
		next_st.prev  = src;
		// Edge detection keeps the pulse at one cycle even if the event is held.
		next_st.pulse = src & ~st.prev; // R4 R7
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_pulse = st.pulse;

endmodule // pam_ovf_pulse

// ===== core/pam_mux.sv
// Port A alternate-function multiplexer with fetch-source decode and FIFO data path.
//
// Function
// R1: Fetch source pin high sends every code fetch to external memory.
// R2: Fetch source pin low sends fetches external only at or above 0x1b40.
// R3: Pin 0 is port I/O when unselected, timer 0 overflow pulse when selected.
// R4: Timer 0 overflow output is high exactly one clock per overflow.
// R5: In timer 0 split mode the low-byte counter makes the pulse.
// R6: Pin 1 is port I/O when unselected, timer 1 overflow pulse when selected.
// R7: Timer 1 overflow output is high exactly one clock per overflow.
// R8: In timer 1 split mode the low-byte counter makes the pulse.
// R9: Pin 2 is port I/O or active-low external memory output enable.
// R10: Pin 3 is port I/O or active-low external memory chip select.
// R11: Pin 4 is port I/O or active-low external FIFO write strobe.
// R12: Pin 5 is port I/O or active-low external FIFO read strobe.
// R13: Pin 6 defaults to port I/O and carries serial port zero data when selected.
// R14: Serial port zero output carries data only in mode 0, else stays 1.
// R15: Pin 7 defaults to port I/O and carries serial port one data when selected.
// R16: Serial port one output carries data only in mode 0, else stays 1.
// R17: Selected FIFO strobes move data bus bytes between internal and external FIFOs.
// R18: After reset every select bit is clear and every pin is an undriven input.
// R19: Selection switches each pin mux, taking effect at the next clock edge.
`timescale 1ns/1ps
module pam_mux (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rstn,
	input  wire pam_pkg::pam_bus_t i_bus,
	output logic [7:0]             o_rdata,
	input  wire pam_pkg::pam_alt_t i_alt,
	input  wire logic              i_fetch_source_select,
	input  wire logic [15:0]       i_code_addr,
	output logic                   o_fetch_external,
	input  wire logic [7:0]        i_pa_in,
	output logic [7:0]             o_pa_out,
	output logic [7:0]             o_pa_oe_n,
	input  wire logic [7:0]        i_db_in,
	output logic [7:0]             o_db_out,
	output logic                   o_db_oe_n,
	input  wire logic [7:0]        i_fifo_wdata,
	output logic [7:0]             o_fifo_rdata,
	output logic                   o_fifo_rvalid
);
	pam_pkg::pam_state_t st;
	pam_pkg::pam_state_t next_st;
	logic                timer0_overflow_pulse;
	logic                timer1_overflow_pulse;
	logic [7:0]          alt;

	pam_ovf_pulse u_t0 (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_ovf     (i_alt.t0_ovf),
		.i_lo_ovf  (i_alt.t0_lo_ovf),
		.i_split   (i_alt.t0_split),
		.o_pulse   (timer0_overflow_pulse)
	); // R5

	pam_ovf_pulse u_t1 (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_ovf     (i_alt.t1_ovf),
		.i_lo_ovf  (i_alt.t1_lo_ovf),
		.i_split   (i_alt.t1_split),
		.o_pulse   (timer1_overflow_pulse)
	); // R8

	always_comb begin
		alt                   = '0;
		alt[pam_pkg::BIT_T0]  = timer0_overflow_pulse; // R3
		alt[pam_pkg::BIT_T1]  = timer1_overflow_pulse; // R6
		alt[pam_pkg::BIT_OE]  = i_alt.mem_oe_n; // R9
		alt[pam_pkg::BIT_CS]  = i_alt.mem_cs_n; // R10
		alt[pam_pkg::BIT_FWR] = i_alt.fifo_wr_n; // R11
		alt[pam_pkg::BIT_FRD] = i_alt.fifo_rd_n; // R12
		// Outside the synchronous mode the serial data pins idle high.
		alt[pam_pkg::BIT_U0]  = (i_alt.u0_mode == pam_pkg::UART_SYNC_MODE) ?
			i_alt.u0_data : 1'b1; // R14
		alt[pam_pkg::BIT_U1]  = (i_alt.u1_mode == pam_pkg::UART_SYNC_MODE) ?
			i_alt.u1_data : 1'b1; // R16
	end

	always_comb begin
		next_st = st;

		// Two-stage synchronisers for every pin-level input.
		next_st.fs_s1 = i_fetch_source_select;
		next_st.fs_s2 = st.fs_s1;
		next_st.pa_s1 = i_pa_in;
		next_st.pa_s2 = st.pa_s1;
		next_st.db_s1 = i_db_in;
		next_st.db_s2 = st.db_s1;

		next_st.fetch_ext = st.fs_s2 | (i_code_addr >= pam_pkg::CODE_BOUNDARY); // R1 R2

		// Each pin picks port data or its alternate signal from its own select bit.
		for (int i = 0; i < 8; i++) begin
			if (st.sel[i]) begin
				next_st.pa_out[i]  = alt[i]; // R13 R15 R19
				next_st.pa_oe_n[i] = 1'b0;
			end else begin
				next_st.pa_out[i]  = st.dout[i];
				next_st.pa_oe_n[i] = ~st.dir[i];
			end
		end

		// The data bus drives internal FIFO bytes while pin 4 is selected and the write strobe is low.
		next_st.db_out  = i_fifo_wdata;
		next_st.db_oe_n = ~(st.sel[pam_pkg::BIT_FWR] & ~i_alt.fifo_wr_n); // R17

		// A read byte is taken as the read strobe rises again.
		next_st.frd_prev    = i_alt.fifo_rd_n;
		next_st.fifo_rvalid = st.sel[pam_pkg::BIT_FRD] & i_alt.fifo_rd_n & ~st.frd_prev; // R17
		if (next_st.fifo_rvalid) begin
			next_st.fifo_rdata = st.db_s2;
		end

		if (i_bus.wr) begin
			unique case (i_bus.addr)
				pam_pkg::REG_SEL: begin
					next_st.sel = i_bus.wdata;
				end
				pam_pkg::REG_DOUT: begin
					next_st.dout = i_bus.wdata;
				end
				pam_pkg::REG_DIR: begin
					next_st.dir = i_bus.wdata;
				end
				default: begin
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe; unmapped reads give zero.
		next_st.rdata = '0;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				pam_pkg::REG_SEL: begin
					next_st.rdata = st.sel;
				end
				pam_pkg::REG_DOUT: begin
					next_st.rdata = st.dout;
				end
				pam_pkg::REG_DIR: begin
					next_st.rdata = st.dir;
				end
				pam_pkg::REG_PIN: begin
					next_st.rdata = st.pa_s2;
				end
				pam_pkg::REG_STAT: begin
					next_st.rdata[pam_pkg::STAT_FETCH_SRC] = st.fs_s2;
					next_st.rdata[pam_pkg::STAT_FETCH_EXT] = st.fetch_ext;
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st             <= '0;
			st.sel         <= pam_pkg::SEL_RST; // R18
			st.dout        <= pam_pkg::DOUT_RST;
			st.dir         <= pam_pkg::DIR_RST;
			st.pa_oe_n     <= pam_pkg::OE_N_RST; // R18
			st.rdata       <= pam_pkg::RDATA_RST;
			st.db_oe_n     <= 1'b1;
			st.frd_prev    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata          = st.rdata;
	assign o_fetch_external = st.fetch_ext;
	assign o_pa_out         = st.pa_out;
	assign o_pa_oe_n        = st.pa_oe_n;
	assign o_db_out         = st.db_out;
	assign o_db_oe_n        = st.db_oe_n;
	assign o_fifo_rdata     = st.fifo_rdata;
	assign o_fifo_rvalid    = st.fifo_rvalid;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);

	fetch_ext_pin_a: assert property ( // R1
		st.fs_s2 |=> o_fetch_external)
		else $error("fetch not external while fetch source pin is high");

	fetch_boundary_a: assert property ( // R2
		!st.fs_s2 |=> o_fetch_external == ($past(i_code_addr) >= pam_pkg::CODE_BOUNDARY))
		else $error("fetch source wrong around the internal code boundary");

	pin0_timer_a: assert property ( // R3
		st.sel[0] ##1 st.sel[0] |=> o_pa_out[0] == $past(timer0_overflow_pulse)
			&& !o_pa_oe_n[0])
		else $error("pin 0 does not carry the timer 0 pulse");

	t0_pulse_width_a: assert property ( // R4
		timer0_overflow_pulse |=> !timer0_overflow_pulse)
		else $error("timer 0 pulse longer than one cycle");

	t0_split_src_a: assert property ( // R5
		!i_alt.t0_split && i_alt.t0_ovf && !$past(i_alt.t0_ovf) && !$past(i_alt.t0_split)
			|=> timer0_overflow_pulse)
		else $error("timer 0 overflow did not pulse");

	t0_split_lo_a: assert property ( // R5
		i_alt.t0_split && !i_alt.t0_lo_ovf |=> !timer0_overflow_pulse)
		else $error("timer 0 split pulse without low-byte overflow");

	t1_pulse_width_a: assert property ( // R7
		timer1_overflow_pulse |=> !timer1_overflow_pulse)
		else $error("timer 1 pulse longer than one cycle");

	t1_split_lo_a: assert property ( // R8
		i_alt.t1_split && i_alt.t1_lo_ovf && !$past(i_alt.t1_lo_ovf) && $past(i_alt.t1_split)
			|=> timer1_overflow_pulse)
		else $error("timer 1 low-byte overflow did not pulse");

	pin1_timer_a: assert property ( // R6
		st.sel[1] ##1 st.sel[1] |=> o_pa_out[1] == $past(timer1_overflow_pulse))
		else $error("pin 1 does not carry the timer 1 pulse");

	mem_strobes_a: assert property ( // R9
		st.sel[2] && st.sel[3] |=> o_pa_out[2] == $past(i_alt.mem_oe_n)
			&& o_pa_out[3] == $past(i_alt.mem_cs_n))
		else $error("memory enable or select not on pins 2 and 3");

	fifo_strobes_a: assert property ( // R11
		st.sel[4] && st.sel[5] |=> o_pa_out[4] == $past(i_alt.fifo_wr_n)
			&& o_pa_out[5] == $past(i_alt.fifo_rd_n))
		else $error("FIFO strobes not on pins 4 and 5");

	uart_idle_high_a: assert property ( // R14
		st.sel[6] && i_alt.u0_mode != 2'h0 |=> o_pa_out[6])
		else $error("serial port zero pin not high outside mode 0");

	serial_port_one_data_a: assert property ( // R16
		st.sel[7] |=> o_pa_out[7] == ($past(i_alt.u1_mode) == 2'h0 ?
			$past(i_alt.u1_data) : 1'b1))
		else $error("serial port one pin wrong for its mode");

	gpio_mode_a: assert property ( // R19
		!st.sel[0] |=> o_pa_out[0] == $past(st.dout[0]) && o_pa_oe_n[0] == !$past(st.dir[0]))
		else $error("unselected pin 0 not following port data");

	db_drive_a: assert property ( // R17
		st.sel[4] && !i_alt.fifo_wr_n |=> !o_db_oe_n && o_db_out == $past(i_fifo_wdata))
		else $error("data bus not driven during FIFO write strobe");

	read_once_a: assert property ( // R17
		o_fifo_rvalid |=> !o_fifo_rvalid)
		else $error("FIFO read valid longer than one cycle");

	reset_idle_a: assert property ( // R18
		$rose(i_rstn) |-> o_pa_oe_n == 8'hff && st.sel == 8'h00)
		else $error("pins not idle inputs after reset");

	t0_pin_c: cover property (st.sel[0] && o_pa_out[0]);
	split_c: cover property (i_alt.t1_split && timer1_overflow_pulse);
	fifo_read_c: cover property (o_fifo_rvalid);
	fetch_int_c: cover property (!o_fetch_external ##1 o_fetch_external);

endmodule // pam_mux

// ===== bench/pam_ext_fifo.sv
// Behavioural external FIFO that answers the port A read strobe on the data bus.
`timescale 1ns/1ps
module pam_ext_fifo (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rd_n,
	input  wire logic [7:0] i_byte,
	output logic [7:0]      o_db
);
	logic [7:0] last = 8'h00;
	// A released bus toggles every cycle so that a stale byte cannot pass for a fresh one.
	always @(posedge i_ref_clk) begin
		if (!i_rd_n) begin
			last <= i_byte;
		end else begin
			last <= ~last;
		end
	end
	assign o_db = last;
endmodule // pam_ext_fifo

// ===== bench/test_port_a_alt_function_mux.sv
// Self-checking bench for the port A alternate-function multiplexer.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
	$display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module test_port_a_alt_function_mux;
	logic              clk;
	logic              rstn;
	pam_pkg::pam_bus_t bus;
	pam_pkg::pam_alt_t alt;
	logic              fs;
	logic [15:0]       caddr;
	logic [7:0]        wdat, fbyte, rdata, pa_out, pa_oe_n, db_out, fdat, ext_db;
	logic [7:0]        pa_lvl, db_lvl;
	logic              fext, db_oe_n, fvalid;
	int                err_total, checked;
	// Undriven pins are pulled up.
	assign pa_lvl = pa_out | pa_oe_n;
	assign db_lvl = db_oe_n ? ext_db : db_out;
	pam_mux dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata), .i_alt(alt),
		.i_fetch_source_select(fs), .i_code_addr(caddr), .o_fetch_external(fext),
		.i_pa_in(pa_lvl), .o_pa_out(pa_out), .o_pa_oe_n(pa_oe_n), .i_db_in(db_lvl),
		.o_db_out(db_out), .o_db_oe_n(db_oe_n), .i_fifo_wdata(wdat), .o_fifo_rdata(fdat),
		.o_fifo_rvalid(fvalid));
	pam_ext_fifo ext_u (.i_ref_clk(clk), .i_rd_n(pa_lvl[5]), .i_byte(fbyte), .o_db(ext_db));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task go(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		`CHK(rdata, e)
	endtask
	task automatic tmr(input int t, input bit s, input bit k);
		int n;
		n = 0;
		@(posedge clk);
		if (t == 0) begin
			alt.t0_split <= s;
			alt.t0_ovf <= !k;
			alt.t0_lo_ovf <= k;
		end else begin
			alt.t1_split <= s;
			alt.t1_ovf <= !k;
			alt.t1_lo_ovf <= k;
		end
		repeat (6) begin
			go(1);
			if (pa_out[t] === 1'b1) n++;
		end
		`CHK(n, int'(s == k))
		@(posedge clk);
		{alt.t0_ovf, alt.t0_lo_ovf, alt.t1_ovf, alt.t1_lo_ovf} <= 4'h0;
		go(3);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#100us;
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		finish_test();
	end
	initial begin
		rstn = 1'b0;
		bus = '0;
		alt = '0;
		{alt.mem_oe_n, alt.mem_cs_n, alt.fifo_wr_n, alt.fifo_rd_n} = 4'hf;
		fs = 1'b0;
		caddr = 16'h0000;
		wdat = 8'h00;
		fbyte = 8'h00;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		go(1);
		`CHK(pa_oe_n, pam_pkg::OE_N_RST)
		rd(pam_pkg::REG_SEL, pam_pkg::SEL_RST);
		wr(3'h5, 8'hff);
		rd(3'h5, 8'h00);
		wr(pam_pkg::REG_DOUT, 8'h55);
		wr(pam_pkg::REG_DIR, 8'h0f);
		go(1);
		`CHK(pa_out, 8'h55)
		`CHK(pa_oe_n, 8'hf0)
		go(3);
		rd(pam_pkg::REG_PIN, 8'hf5);
		$display("test reset and port io done");
		wr(pam_pkg::REG_SEL, 8'h03);
		for (int t = 0; t < 2; t++)
			for (int s = 0; s < 2; s++)
				for (int k = 0; k < 2; k++) tmr(t, s[0], k[0]);
		$display("test timer pulses done");
		wr(pam_pkg::REG_SEL, 8'h3c);
		@(posedge clk);
		{alt.fifo_rd_n, alt.fifo_wr_n, alt.mem_cs_n, alt.mem_oe_n} <= 4'ha;
		go(1);
		`CHK(pa_out[5:2], 4'ha)
		`CHK(pa_oe_n[5:2], 4'h0)
		@(posedge clk);
		{alt.fifo_rd_n, alt.fifo_wr_n, alt.mem_cs_n, alt.mem_oe_n} <= 4'h5;
		go(1);
		`CHK(pa_out[5:2], 4'h5)
		@(posedge clk);
		{alt.fifo_rd_n, alt.fifo_wr_n, alt.mem_cs_n, alt.mem_oe_n} <= 4'hf;
		go(3);
		$display("test memory and strobe pins done");
		wr(pam_pkg::REG_SEL, 8'hc0);
		// Mode 0 is visited twice with swapped data so both pins must really pass data.
		for (int m = 0; m < 5; m++) begin
			@(posedge clk);
			{alt.u0_mode, alt.u1_mode, alt.u0_data, alt.u1_data} <= {m[1:0], m[1:0], m[2], ~m[2]};
			go(1);
			`CHK(pa_out[7:6], (m[1:0] == 2'h0) ? {~m[2], m[2]} : 2'b11)
		end
		$display("test serial outputs done");
		@(posedge clk);
		caddr <= 16'h1b3f;
		go(1);
		`CHK(fext, 1'b0)
		@(posedge clk);
		caddr <= 16'h1b40;
		go(1);
		`CHK(fext, 1'b1)
		@(posedge clk);
		caddr <= 16'h0000;
		fs <= 1'b1;
		go(4);
		`CHK(fext, 1'b1)
		rd(pam_pkg::REG_STAT, 8'h03);
		@(posedge clk);
		fs <= 1'b0;
		$display("test fetch source done");
		wr(pam_pkg::REG_SEL, 8'h30);
		@(posedge clk);
		wdat <= 8'ha5;
		alt.fifo_wr_n <= 1'b0;
		go(1);
		`CHK(db_oe_n, 1'b0)
		`CHK(db_out, 8'ha5)
		@(posedge clk);
		alt.fifo_wr_n <= 1'b1;
		go(3);
		`CHK(db_oe_n, 1'b1)
		@(posedge clk);
		fbyte <= 8'h3c;
		alt.fifo_rd_n <= 1'b0;
		go(6);
		@(posedge clk);
		alt.fifo_rd_n <= 1'b1;
		for (int i = 0; i < 6 && fvalid !== 1'b1; i++) go(1);
		`CHK(fvalid, 1'b1)
		`CHK(fdat, 8'h3c)
		$display("test fifo data path done");
		finish_test();
	end
endmodule // test_port_a_alt_function_mux
